/* File: dv/sfec_erase_props.sv */
`timescale 1ns/100ps
module sfec_erase_props
#(
    parameter logic [35:0] BULK_CYCLES    = 36'h32,
    parameter logic [35:0] SECT_CYCLES    = 36'h14,
    parameter logic [35:0] SUBS_CYCLES    = 36'h0A,
    parameter int          SECTOR_LOG2    = 16,
    parameter int          SUBSECTOR_LOG2 = 12
)
(
    // system
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    // link
    input wire logic        cs_n,
    // status and erase request
    input wire logic        wip,
    input wire logic        wel,
    input wire logic        active_power,
    input wire logic        erase_start,
    input wire logic [1:0]  erase_kind,
    input wire logic [31:0] erase_addr,
    input wire logic        erase_done,
    input wire logic        read_accept
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // busy length, frozen with clk_en low like the design
    logic [35:0] busy_len;
    logic [35:0] exp_len;
    assign exp_len = (erase_kind == 2'h0) ? BULK_CYCLES :
                     (erase_kind == 2'h1) ? SECT_CYCLES : SUBS_CYCLES;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_len <= 36'h0;
        else if (erase_start)
            busy_len <= 36'h1;
        else if (wip && clk_en)
            busy_len <= busy_len + 36'h1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    chk_start_busy: assert property (erase_start |-> wip && !wel && active_power)
        else $error("erase start without busy status");
    chk_start_cause: assert property ($rose(wip) |-> erase_start && $past(wel))
        else $error("busy rose without enabled erase");
    chk_done_len: assert property (erase_done |-> !wip && $past(wip) && busy_len == exp_len)
        else $error("erase busy length wrong");
    chk_wip_end: assert property ($fell(wip) |-> erase_done)
        else $error("busy fell without done");
    chk_busy_quiet: assert property ($past(wip) && wip |-> !erase_start && !read_accept)
        else $error("command taken while busy");
    chk_frame_end: assert property (erase_start |-> cs_n && $past(cs_n, 3))
        else $error("erase started inside a frame");
    chk_bulk_addr: assert property (erase_start && erase_kind == 2'h0 |-> erase_addr == 32'h0)
        else $error("bulk erase address not zero");
    chk_sect_align: assert property (erase_start && erase_kind == 2'h1
        |-> erase_addr[SECTOR_LOG2-1:0] == '0) else $error("sector base unaligned");
    chk_subs_align: assert property (erase_start && erase_kind == 2'h2
        |-> erase_addr[SUBSECTOR_LOG2-1:0] == '0) else $error("subsector base unaligned");
    chk_power_sel: assert property ((!cs_n) [*6] |-> active_power)
        else $error("selected but not active");
    chk_standby_idle: assert property ((cs_n && !wip) [*6] |-> !active_power)
        else $error("idle but not standby");
endmodule

/* File: dv/sfec_host_model.sv */
`timescale 1ns/100ps
module sfec_host_model
(
    // link to the device
    output logic shift_clock,
    output logic cs_n,
    output logic serial_in_line
);
    initial
    begin
        shift_clock = 1'b0;
        cs_n = 1'b1;
        serial_in_line = 1'b0;
    end
    // one frame msb first; clock stands low between frames, half sets the pace
    task automatic send(input logic [39:0] d, input int n, input int half);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in_line = d[i];
            #(half);
            shift_clock = 1'b1;
            #(half);
            shift_clock = 1'b0;
        end
        #(half);
        cs_n = 1'b1;
        // released line holds nothing useful, so never leave the last bit on it
        serial_in_line = ~serial_in_line;
        #60;
    endtask
endmodule

/* File: dv/sfec_top_test.sv */
`timescale 1ns/100ps
module sfec_top_test;
    // bulk kept long enough for a read frame to land inside it
    localparam logic [35:0] LENS [3] = '{36'h1F4, 36'h14, 36'h0A};
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        clk_en  = 1'b1;
    logic        four    = 1'b0;
    wire logic   shift_clock, cs_n, serial_in_line;
    logic        wip, wel, four_byte_mode, active_power, erase_start, erase_done, read_accept;
    logic [1:0]  erase_kind, s_kind;
    logic [31:0] erase_addr, s_addr;
    logic [31:0] lfsr_state = 32'h17;
    logic [7:0]  read_opcode;
    logic        s_wel, s_wip;
    int          num_errors = 0;
    int          n_tests    = 0;
    int          starts     = 0;
    int          reads      = 0;
    int          len        = 0;
    logic [7:0]  ops [3] = '{sfec_pkg::OP_BULK_ERASE, sfec_pkg::OP_SECT_ERASE,
                             sfec_pkg::OP_SUBS_ERASE};
    always #2 sys_clk = ~sys_clk;
    sfec_top #(.BULK_CYCLES(LENS[0]), .SECT_CYCLES(LENS[1]), .SUBS_CYCLES(LENS[2])) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .shift_clock(shift_clock),
        .cs_n(cs_n), .serial_in_line(serial_in_line), .wip(wip), .wel(wel),
        .four_byte_mode(four_byte_mode), .active_power(active_power),
        .erase_start(erase_start), .erase_kind(erase_kind), .erase_addr(erase_addr),
        .erase_done(erase_done), .read_accept(read_accept), .read_opcode(read_opcode));
    sfec_host_model host (.shift_clock(shift_clock), .cs_n(cs_n),
        .serial_in_line(serial_in_line));
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge sys_clk)
    begin
        if (erase_start === 1'b1)
        begin
            starts++;
            {s_kind, s_addr, s_wel, s_wip} = {erase_kind, erase_addr, wel, wip};
            len = 1;
        end
        // cycles frozen by clk_en low do not advance the erase timer
        else if (wip === 1'b1 && clk_en)
            len++;
        if (read_accept === 1'b1)
            reads++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_addr(input int k, input logic [31:0] a);
        int sh;
        sh = (k == 1) ? sfec_pkg::SECTOR_LOG2 : sfec_pkg::SUBSECTOR_LOG2;
        if (k == 0)
            return 32'h0;
        return (four ? a : {8'h00, a[23:0]}) & ~((32'h1 << sh) - 32'h1);
    endfunction
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // cut drops trailing bits so cs_n rises early; ok says whether a start is due
    task automatic erase(input int k, input bit wen, input int cut, input int half,
                         input bit rd, input bit ok);
        logic [31:0] a;
        int          n, r, nb;
        lfsr_state = lfsr(lfsr_state);
        a = lfsr_state;
        n = starts;
        r = reads;
        nb = (k == 0) ? 8 : (four ? 40 : 32);
        if (wen)
            host.send(40'(sfec_pkg::OP_WRITE_EN), 8, 15);
        host.send((k == 0 ? 40'(ops[k]) : (four ? {ops[k], a} : 40'({ops[k], a[23:0]})))
                  >> cut, nb - cut, half);
        for (int i = 0; i < 30 && starts == n; i++)
            @(negedge sys_clk);
        check("start count", 36'(starts), 36'(n + ok));
        if (ok)
        begin
            check("kind", s_kind, 36'(k));
            check("addr", s_addr, exp_addr(k, a));
            check("wel at start", s_wel, 0);
            check("wip at start", s_wip, 1);
            if (rd)
                host.send({8'h00, sfec_pkg::OP_READ, a[23:0]}, 32, 15);
            for (int i = 0; i < 600 && wip !== 1'b0; i++)
                @(negedge sys_clk);
            check("busy length", 36'(len), LENS[k]);
            check("read while busy", 36'(reads), 36'(r));
            check("standby", active_power, 0);
        end
        $display("test erase kind %0d done", k);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // all frames together take about 20 us; ten times that is a hang
    initial
    begin
        #200000;
        num_errors++;
        tally_and_finish;
    end
    initial
    begin
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        @(negedge sys_clk);
        check("reset", {wip, wel, four_byte_mode, active_power}, 0);
        for (int m = 0; m < 2; m++)
        begin
            if (m == 1)
                host.send(40'(sfec_pkg::OP_ADDR4_ENTER), 8, 15);
            four = m[0];
            check("four byte", four_byte_mode, four);
            for (int k = 0; k < 3; k++)
                erase(k, 1, 0, 15, m == 0 && k == 0, 1);
        end
        host.send(40'(sfec_pkg::OP_ADDR4_EXIT), 8, 15);
        four = 1'b0;
        erase(1, 0, 0, 15, 0, 0);
        erase(0, 1, 1, 15, 0, 0);
        check("wel kept", wel, 1);
        erase(2, 1, 8, 15, 0, 0);
        // slow link clock, and the system clock gated for a while mid-cycle
        fork
            erase(0, 1, 0, 40, 0, 1);
            begin
                @(posedge wip);
                repeat (5) @(posedge sys_clk);
                #1 clk_en = 1'b0;
                repeat (7) @(posedge sys_clk);
                #1 clk_en = 1'b1;
            end
        join
        host.send({8'h00, sfec_pkg::OP_READ, 24'h000100}, 32, 15);
        check("idle read", 36'(reads), 36'(1));
        check("read opcode", read_opcode, sfec_pkg::OP_READ);
        $display("test read done");
        tally_and_finish;
    end
endmodule
bind sfec_top sfec_erase_props #(.BULK_CYCLES(BULK_CYCLES), .SECT_CYCLES(SECT_CYCLES),
    .SUBS_CYCLES(SUBS_CYCLES), .SECTOR_LOG2(SECTOR_LOG2),
    .SUBSECTOR_LOG2(SUBSECTOR_LOG2)) u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(clk_en), .cs_n(cs_n), .wip(wip), .wel(wel), .active_power(active_power),
    .erase_start(erase_start), .erase_kind(erase_kind), .erase_addr(erase_addr),
    .erase_done(erase_done), .read_accept(read_accept));

/* File: rtl/sfec_link_rx.sv */
`timescale 1ns/100ps
module sfec_link_rx
#(
    parameter int SHIFT_W = sfec_pkg::SHIFT_W,
    parameter int CNT_W   = sfec_pkg::CNT_W
)
(
    // link, shift clock domain
    input  wire logic               shift_clock,
    input  wire logic               cs_n,
    input  wire logic               serial_in_line,
    input  wire logic               rst_n,
    // captured frame, stable while cs_n is high
    output logic [CNT_W-1:0]        bit_count,
    output logic [SHIFT_W-1:0]      shift_data
);

    typedef struct packed
    {
        logic [CNT_W-1:0]   cnt;
        logic [SHIFT_W-1:0] shreg;
    } sfec_rx_t;

    sfec_rx_t cur;
    sfec_rx_t next_cur;
    logic     fresh;

    if (SHIFT_W < 40 || CNT_W < 6)
    begin : g_bad_size
        $error("sfec_link_rx: frame register too narrow");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // the clock stops between frames, so the frame start is marked by select
    // itself; captured data is left alone so the system side can read it
    always_ff @(posedge shift_clock or posedge cs_n or negedge rst_n)
    begin
        if (!rst_n)
            fresh <= 1'b1;
        else if (cs_n)
            fresh <= 1'b1;
        else
            fresh <= 1'b0;
    end

    always_comb
    begin
        next_cur = cur;
        if (fresh)
        begin
            next_cur.cnt   = CNT_W'(1); // R20
            next_cur.shreg = {{(SHIFT_W-1){1'b0}}, serial_in_line}; // R20
        end
        else
        begin
            next_cur.shreg = {cur.shreg[SHIFT_W-2:0], serial_in_line}; // R20
            if (cur.cnt != {CNT_W{1'b1}})
                next_cur.cnt = cur.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge shift_clock or negedge rst_n)
    begin
        if (!rst_n)
            cur <= '0;
        else if (!cs_n)
            cur <= next_cur;
    end

    assign bit_count  = cur.cnt;
    assign shift_data = cur.shreg;

endmodule

/* File: rtl/sfec_pkg.sv */
// What this block does
// R1 - bulk erase opcode C7h with write enable latch set erases whole array
// R2 - host issues write enable before bulk erase
// R3 - host lowers select, shifts eight opcode bits, then raises select
// R4 - bulk erase cycle starts as soon as select rises after valid command
// R5 - host waits cycle time or polls status before touching memory after bulk erase
// R6 - write in progress reads 1 during any erase cycle, 0 after
// R7 - write enable latch clears to 0 before any erase cycle completes
// R8 - sector erase opcode D8h with latch set erases addressed sector
// R9 - host sends 24-bit address, or 32-bit in four-byte mode, after opcode
// R10 - any address inside a sector selects that whole sector
// R11 - sector erase cycle starts as soon as select rises after valid command
// R12 - subsector erase with latch set erases addressed subsector
// R13 - any address inside a subsector selects that whole subsector
// R14 - subsector erase cycle starts as soon as select rises after valid command
// R15 - host waits cycle time or polls busy bit before programming again
// R16 - select low means device enabled and in active power mode
// R17 - after select rises stay active until internal cycles end, then standby
// R18 - four-byte mode takes a full 32-bit address
// R19 - host keeps shift clock at or below 108 MHz, 133 MHz on largest part
// R20 - every host bit is latched on the rising shift clock edge
// R21 - read commands during a busy cycle are ignored and do not disturb it
// R22 - erase opcodes with the latch clear are ignored entirely
// R23 - select rising before a complete command and address discards it; read frames of eight bits or more are still accepted; code drops reads of 47+ bits
package sfec_pkg;

    // opcodes
    localparam logic [7:0] OP_WRITE_EN    = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS   = 8'h04;
    localparam logic [7:0] OP_ADDR4_ENTER = 8'hB7;
    localparam logic [7:0] OP_ADDR4_EXIT  = 8'hE9;
    localparam logic [7:0] OP_READ        = 8'h03;
    localparam logic [7:0] OP_FAST_READ   = 8'h0B;
    localparam logic [7:0] OP_BULK_ERASE  = 8'hC7;
    localparam logic [7:0] OP_SECT_ERASE  = 8'hD8;
    localparam logic [7:0] OP_SUBS_ERASE  = 8'h20;

    // frame layout
    localparam int         SHIFT_W     = 40;
    localparam int         CNT_W       = 6;
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_ADDR3  = 6'h20;
    localparam logic [5:0] BITS_ADDR4  = 6'h28;
    localparam logic [5:0] BITS_MAX    = 6'h3F;

    // array geometry, log2 of byte sizes
    localparam int SECTOR_LOG2    = 16;
    localparam int SUBSECTOR_LOG2 = 12;

    // timing
    localparam longint unsigned SYS_CLK_HZ      = 64'd250_000_000;
    localparam longint unsigned ERASE_BULK_MS   = 64'd60_000;
    localparam longint unsigned ERASE_SECT_MS   = 64'd3_000;
    localparam longint unsigned ERASE_SUBS_MS   = 64'd1_500;
    localparam int              TIMER_W         = 36;
    localparam logic [35:0] ERASE_BULK_CYCLES = 36'(ERASE_BULK_MS * (SYS_CLK_HZ / 64'd1000));
    localparam logic [35:0] ERASE_SECT_CYCLES = 36'(ERASE_SECT_MS * (SYS_CLK_HZ / 64'd1000));
    localparam logic [35:0] ERASE_SUBS_CYCLES = 36'(ERASE_SUBS_MS * (SYS_CLK_HZ / 64'd1000));

    // reset values
    localparam logic RST_WEL       = 1'b0;
    localparam logic RST_FOUR_BYTE = 1'b0;
    localparam logic RST_CS_LEVEL  = 1'b1;

    typedef enum logic [1:0]
    {
        SFEC_KIND_BULK = 2'b00,
        SFEC_KIND_SECT = 2'b01,
        SFEC_KIND_SUBS = 2'b10
    } sfec_kind_t;

    typedef enum logic [0:0]
    {
        SFEC_IDLE = 1'b0,
        SFEC_BUSY = 1'b1
    } sfec_state_t;

endpackage

/* File: rtl/sfec_top.sv */
`timescale 1ns/100ps
module sfec_top
#(
    parameter logic [35:0] BULK_CYCLES    = sfec_pkg::ERASE_BULK_CYCLES,
    parameter logic [35:0] SECT_CYCLES    = sfec_pkg::ERASE_SECT_CYCLES,
    parameter logic [35:0] SUBS_CYCLES    = sfec_pkg::ERASE_SUBS_CYCLES,
    parameter int          SECTOR_LOG2    = sfec_pkg::SECTOR_LOG2,
    parameter int          SUBSECTOR_LOG2 = sfec_pkg::SUBSECTOR_LOG2
)
(
    // system
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // serial link from host
    input  wire logic        shift_clock,
    input  wire logic        cs_n,
    input  wire logic        serial_in_line,
    // status
    output logic             wip,
    output logic             wel,
    output logic             four_byte_mode,
    output logic             active_power,
    // erase request to the array
    output logic             erase_start,
    output logic [1:0]       erase_kind,
    output logic [31:0]      erase_addr,
    output logic             erase_done,
    // accepted read frames
    output logic             read_accept,
    output logic [7:0]       read_opcode
);

    typedef struct packed
    {
        logic [2:0]                     cs_s;
        logic                           cs_level;
        logic                           four_byte;
        logic                           wel;
        sfec_pkg::sfec_state_t          state;
        sfec_pkg::sfec_kind_t           kind;
        logic [sfec_pkg::TIMER_W-1:0]   timer;
        logic [31:0]                    addr;
        logic                           start;
        logic                           done;
        logic                           active;
        logic                           rd_acc;
        logic [7:0]                     rd_op;
    } sfec_sys_t;

    sfec_sys_t                      cur;
    sfec_sys_t                      next_cur;
    logic [sfec_pkg::CNT_W-1:0]     rx_cnt;
    logic [sfec_pkg::SHIFT_W-1:0]   rx_data;
    logic                           cs_rise;
    logic [7:0]                     op;
    logic [31:0]                    frame_addr;
    logic                           addr_ok;

    if (BULK_CYCLES == 36'h0 || SECT_CYCLES == 36'h0 || SUBS_CYCLES == 36'h0
        || SUBSECTOR_LOG2 < 1 || SECTOR_LOG2 <= SUBSECTOR_LOG2 || SECTOR_LOG2 > 31)
    begin : g_bad_param
        $error("sfec_top: unusable erase timing or geometry");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link receiver on the shift clock
    sfec_link_rx u_rx
    (
        .shift_clock    (shift_clock),
        .cs_n           (cs_n),
        .serial_in_line (serial_in_line),
        .rst_n          (rst_n),
        .bit_count      (rx_cnt),
        .shift_data     (rx_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // frame decode helpers

    function automatic logic [7:0] frame_opcode(input logic [5:0] n,
                                                input logic [39:0] d);
        logic [7:0] o;
        o = 8'h00;
        if (n == sfec_pkg::BITS_ADDR4)
            o = d[39:32];
        else if (n == sfec_pkg::BITS_ADDR3)
            o = d[31:24];
        else
            o = d[7:0];
        return o;
    endfunction

    function automatic logic [31:0] align_down(input logic [31:0] a, input int log2);
        logic [31:0] m;
        m = ~((32'h1 << log2) - 32'h1);
        return a & m;
    endfunction

    // the frame is only read once select is seen high on two agreeing
    // flops; by then the host has stopped the shift clock, so the words
    // are quiet and need no further crossing
    assign cs_rise = !cur.cs_level && cur.cs_s[1] && cur.cs_s[2];

    // exact bit count only: short or overlong frames start no sector or subsector erase
    assign addr_ok = cur.four_byte ? (rx_cnt == sfec_pkg::BITS_ADDR4)
                                   : (rx_cnt == sfec_pkg::BITS_ADDR3); // R9 R18 R23

    always_comb
    begin
        op         = 8'h00;
        frame_addr = 32'h0;
        if (rx_cnt == sfec_pkg::BITS_OPCODE)
            op = rx_data[7:0];
        else if (addr_ok)
            op = frame_opcode(rx_cnt, rx_data);
        else if (rx_cnt > sfec_pkg::BITS_OPCODE)
            op = frame_opcode(sfec_pkg::BITS_OPCODE, rx_data >> (rx_cnt - 6'h08));
        if (cur.four_byte)
            frame_addr = rx_data[31:0]; // R18
        else
            frame_addr = {8'h00, rx_data[23:0]};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command engine and erase timer
    always_comb
    begin
        next_cur        = cur;
        next_cur.start  = 1'b0;
        next_cur.done   = 1'b0;
        next_cur.rd_acc = 1'b0;
        next_cur.cs_s   = {cur.cs_s[1:0], cs_n};
        if (cur.cs_s[1] == cur.cs_s[2])
            next_cur.cs_level = cur.cs_s[2];

        case (cur.state)
            sfec_pkg::SFEC_IDLE:
            begin
                if (cs_rise && rx_cnt == sfec_pkg::BITS_OPCODE)
                begin
                    case (op)
                        sfec_pkg::OP_WRITE_EN:    next_cur.wel = 1'b1;
                        sfec_pkg::OP_WRITE_DIS:   next_cur.wel = 1'b0;
                        sfec_pkg::OP_ADDR4_ENTER: next_cur.four_byte = 1'b1;
                        sfec_pkg::OP_ADDR4_EXIT:  next_cur.four_byte = 1'b0;
                        sfec_pkg::OP_BULK_ERASE:
                        begin
                            if (cur.wel) // R1 R22
                            begin
                                next_cur.state = sfec_pkg::SFEC_BUSY; // R4
                                next_cur.kind  = sfec_pkg::SFEC_KIND_BULK;
                                next_cur.addr  = 32'h0;
                                next_cur.timer = sfec_pkg::TIMER_W'(BULK_CYCLES - 36'h1);
                                next_cur.start = 1'b1; // R1 R4
                                next_cur.wel   = 1'b0; // R7
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
                if (cs_rise && addr_ok && cur.wel) // R22 R23
                begin
                    if (op == sfec_pkg::OP_SECT_ERASE)
                    begin
                        next_cur.state = sfec_pkg::SFEC_BUSY; // R11
                        next_cur.kind  = sfec_pkg::SFEC_KIND_SECT;
                        next_cur.addr  = align_down(frame_addr, SECTOR_LOG2); // R8 R10
                        next_cur.timer = sfec_pkg::TIMER_W'(SECT_CYCLES - 36'h1);
                        next_cur.start = 1'b1; // R8 R11
                        next_cur.wel   = 1'b0; // R7
                    end
                    else if (op == sfec_pkg::OP_SUBS_ERASE)
                    begin
                        next_cur.state = sfec_pkg::SFEC_BUSY; // R14
                        next_cur.kind  = sfec_pkg::SFEC_KIND_SUBS;
                        next_cur.addr  = align_down(frame_addr, SUBSECTOR_LOG2); // R12 R13
                        next_cur.timer = sfec_pkg::TIMER_W'(SUBS_CYCLES - 36'h1);
                        next_cur.start = 1'b1; // R12 R14
                        next_cur.wel   = 1'b0; // R7
                    end
                end
                if (cs_rise && rx_cnt >= sfec_pkg::BITS_OPCODE
                    && (op == sfec_pkg::OP_READ || op == sfec_pkg::OP_FAST_READ))
                begin
                    next_cur.rd_acc = 1'b1;
                    next_cur.rd_op  = op;
                end
            end
            sfec_pkg::SFEC_BUSY:
            begin
                // every frame, reads included, is dropped while busy
                if (cur.timer == '0) // R21
                begin
                    next_cur.state = sfec_pkg::SFEC_IDLE;
                    next_cur.done  = 1'b1;
                end
                else
                begin
                    next_cur.timer = cur.timer - sfec_pkg::TIMER_W'(1);
                end
            end
            default:
            begin
                next_cur.state = sfec_pkg::SFEC_IDLE;
            end
        endcase

        // enabled while selected, held active until the cycle ends
        next_cur.active = !next_cur.cs_level
                          || next_cur.state == sfec_pkg::SFEC_BUSY; // R16 R17

        if (!clk_en)
            next_cur = cur;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur           <= '0;
            cur.cs_s      <= 3'h7;
            cur.cs_level  <= sfec_pkg::RST_CS_LEVEL;
            cur.four_byte <= sfec_pkg::RST_FOUR_BYTE;
            cur.wel       <= sfec_pkg::RST_WEL;
            cur.state     <= sfec_pkg::SFEC_IDLE;
            cur.kind      <= sfec_pkg::SFEC_KIND_BULK;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign wip            = (cur.state == sfec_pkg::SFEC_BUSY); // R6
    assign wel            = cur.wel;
    assign four_byte_mode = cur.four_byte;
    assign active_power   = cur.active;
    assign erase_start    = cur.start;
    assign erase_kind     = cur.kind;
    assign erase_addr     = cur.addr;
    assign erase_done     = cur.done;
    assign read_accept    = cur.rd_acc;
    assign read_opcode    = cur.rd_op;

endmodule
